//--- dtc_pkg.sv
// package: constants, register map and types for the dual-channel temperature conversion controller
//
// Notes on behaviour
// - standby input low means standby, high runs
// - standby keeps results and thresholds unchanged
// - address select pins captured once after reset
// - started conversion does remote then local unprompted
// - both channels always converted, even unused ones
// - each channel integrates about sixty milliseconds
// - one eight-bit value per channel
// - results stored, compared with four thresholds
// - start by command or auto trigger, publish at end
// - busy bit set during conversion, cleared after
// - reads during conversion return previous results
// - interrupt output open drain, pulls low only
// - standby during conversion aborts, results discarded
// - hardware standby overrides software start commands
// - configuration halt bit gives software standby
// - results signed two's complement, one degree per lsb
package dtc_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ       = 125_000_000;
  localparam int unsigned CHAN_TIME_MS      = 60;
  localparam int unsigned CHAN_CYCLES       = CLK_FREQ_HZ / 1000 * CHAN_TIME_MS;
  localparam int unsigned AUTO_PERIOD_MS    = 1000;
  localparam int unsigned AUTO_PERIOD_CYCLES = CLK_FREQ_HZ / 1000 * AUTO_PERIOD_MS;

  // ----------------------------------------------------------------------
  // register offsets (word addresses on the plain register port)
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_REMOTE_TEMP = 4'h0;
  localparam logic [3:0] REG_LOCAL_TEMP  = 4'h1;
  localparam logic [3:0] REG_STATUS      = 4'h2;
  localparam logic [3:0] REG_CONFIG      = 4'h3;
  localparam logic [3:0] REG_LOCAL_HIGH  = 4'h4;
  localparam logic [3:0] REG_LOCAL_LOW   = 4'h5;
  localparam logic [3:0] REG_REMOTE_HIGH = 4'h6;
  localparam logic [3:0] REG_REMOTE_LOW  = 4'h7;
  localparam logic [3:0] REG_ONE_SHOT    = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK    = 4'h9;
  localparam logic [3:0] REG_ADDR        = 4'hA;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned ST_BUSY_BIT    = 7;
  localparam int unsigned ST_LHIGH_BIT   = 6;
  localparam int unsigned ST_LLOW_BIT    = 5;
  localparam int unsigned ST_RHIGH_BIT   = 4;
  localparam int unsigned ST_RLOW_BIT    = 3;
  localparam int unsigned ST_DONE_BIT    = 0;
  localparam int unsigned CFG_HALT_BIT   = 6;
  localparam int unsigned CFG_AUTO_BIT   = 0;
  localparam int unsigned EVT_WIDTH      = 5;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] TEMP_RST        = 8'h00;
  localparam logic [7:0] HIGH_RST        = 8'h46;
  localparam logic [7:0] LOW_RST         = 8'hC9;
  localparam logic [7:0] CONFIG_RST      = 8'h01;
  localparam logic [7:0] MASK_RST        = 8'h00;

  typedef enum logic [1:0] {
    DTC_IDLE,
    DTC_REMOTE,
    DTC_LOCAL
  } dtc_state_type;

endpackage

//--- dtc_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module dtc_sync
  import dtc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             en_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else if (en_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule
`default_nettype wire

//--- dtc_timer.sv
// loadable down counter that pulses when the interval expires
`timescale 1ns/10ps
`default_nettype none
module dtc_timer
  import dtc_pkg::*;
#(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             en_i,
  input  wire logic             load_i,
  input  wire logic             run_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  done_o
);

  logic [WIDTH-1:0] remain;

  // ----------------------------------------------------------------------
  // load restarts the interval, run lets it drain
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= '0;
    end else if (en_i) begin
      if (load_i) begin
        remain <= count_i;
      end else if (run_i && remain != '0) begin
        remain <= remain - 1'b1;
      end
    end
  end

  // one cycle before zero, so a load of N gives N cycles exactly
  // not gated by load: the sequencer derives load from done, so that would loop
  assign done_o = run_i && (remain == WIDTH'(1));

endmodule
`default_nettype wire

//--- dtc_top.sv
// conversion sequencer and register file of the dual-channel temperature controller
`timescale 1ns/10ps
`default_nettype none
module dtc_top
  import dtc_pkg::*;
#(
  parameter int unsigned CHAN_COUNT = CHAN_CYCLES,
  parameter int unsigned AUTO_COUNT = AUTO_PERIOD_CYCLES,
  parameter int unsigned CNT_WIDTH  = 28
) (
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_N_I,
  input  wire logic       CLK_EN_I,
  // pins
  input  wire logic       HW_STANDBY_IN_N_I,
  input  wire logic       ADDR_SELECT_0_I,
  input  wire logic       ADDR_SELECT_1_I,
  output logic            ALERT_OE_O,
  output logic            ALERT_O,
  // measurement front end
  input  wire logic [7:0] REMOTE_SAMPLE_I,
  input  wire logic [7:0] LOCAL_SAMPLE_I,
  output logic            ADC_ACTIVE_O,
  // register port
  input  wire logic [3:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  output logic [7:0]      REG_RDATA_O,
  // decoded state
  output logic [1:0]      BUS_ADDRESS_O,
  output logic            IRQ_O
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       standby_hw;
  logic [1:0] addr_sel;

  dtc_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .en_i    (CLK_EN_I),
    .d_i     ({HW_STANDBY_IN_N_I, ADDR_SELECT_1_I, ADDR_SELECT_0_I}),
    .q_o     (pins_sync)
  );

  // low level on the pin is standby
  assign standby_hw = !pins_sync[2];
  assign addr_sel   = pins_sync[1:0];

  // ----------------------------------------------------------------------
  // address capture once after reset release
  // ----------------------------------------------------------------------
  // wait for the synchroniser to fill before trusting the pins
  logic [1:0] addr_wait;
  logic       addr_taken;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      addr_wait     <= 2'h0;
      addr_taken    <= 1'b0;
      BUS_ADDRESS_O <= 2'h0;
    end else if (CLK_EN_I) begin
      if (!addr_taken) begin
        if (addr_wait == 2'h2) begin
          BUS_ADDRESS_O <= addr_sel;
          addr_taken    <= 1'b1;
        end else begin
          addr_wait <= addr_wait + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------------
  logic [7:0] config_reg;
  logic [7:0] irq_mask;
  logic [7:0] local_high;
  logic [7:0] local_low;
  logic [7:0] remote_high;
  logic [7:0] remote_low;
  logic       one_shot_req;
  logic       halt_sw;
  logic       auto_mode;
  logic       standby;

  assign halt_sw   = config_reg[CFG_HALT_BIT];
  assign auto_mode = config_reg[CFG_AUTO_BIT];
  assign standby   = standby_hw || halt_sw;

  // thresholds change only by software writes, never by standby
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      config_reg  <= CONFIG_RST;
      irq_mask    <= MASK_RST;
      local_high  <= HIGH_RST;
      local_low   <= LOW_RST;
      remote_high <= HIGH_RST;
      remote_low  <= LOW_RST;
    end else if (CLK_EN_I && REG_WR_I) begin
      case (REG_ADDR_I)
        REG_CONFIG:      config_reg  <= REG_WDATA_I;
        REG_IRQ_MASK:    irq_mask    <= REG_WDATA_I;
        REG_LOCAL_HIGH:  local_high  <= REG_WDATA_I;
        REG_LOCAL_LOW:   local_low   <= REG_WDATA_I;
        REG_REMOTE_HIGH: remote_high <= REG_WDATA_I;
        REG_REMOTE_LOW:  remote_low  <= REG_WDATA_I;
        default: ;
      endcase
    end
  end

  // any write to the one-shot address requests a conversion
  assign one_shot_req = REG_WR_I && (REG_ADDR_I == REG_ONE_SHOT);

  // ----------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------
  dtc_state_type state;
  dtc_state_type next_state;
  logic          chan_done;
  logic          abort_conv;
  logic          start_conv;
  logic          chan_load;
  logic          auto_pending;
  logic [7:0]    remote_shadow;
  logic          finish;

  // hardware standby blocks even the one-shot; software halt does not
  assign start_conv = !standby_hw &&
                      ((one_shot_req) || (auto_pending && !halt_sw));
  // pin standby or a write setting halt cuts a running conversion;
  // a halt already set still lets a one-shot run to its end
  assign abort_conv = standby_hw ||
                      (REG_WR_I && REG_ADDR_I == REG_CONFIG && REG_WDATA_I[CFG_HALT_BIT]);
  assign finish     = (state == DTC_LOCAL) && chan_done && !abort_conv;

  // sequencer moves remote then local with no further command
  always_comb begin
    next_state = state;
    case (state)
      DTC_IDLE: begin
        if (start_conv) begin
          next_state = DTC_REMOTE;
        end
      end
      DTC_REMOTE: begin
        if (abort_conv) begin
          next_state = DTC_IDLE;
        end else if (chan_done) begin
          next_state = DTC_LOCAL;
        end
      end
      DTC_LOCAL: begin
        if (abort_conv || chan_done) begin
          next_state = DTC_IDLE;
        end
      end
      default: next_state = DTC_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= DTC_IDLE;
    end else if (CLK_EN_I) begin
      state <= next_state;
    end
  end

  // a fresh interval per channel
  assign chan_load = (state == DTC_IDLE && next_state == DTC_REMOTE) ||
                     (state == DTC_REMOTE && next_state == DTC_LOCAL);

  dtc_timer #(
    .WIDTH (CNT_WIDTH)
  ) u_chan_timer (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .en_i    (CLK_EN_I),
    .load_i  (chan_load),
    .run_i   (state != DTC_IDLE),
    .count_i (CNT_WIDTH'(CHAN_COUNT)),
    .done_o  (chan_done)
  );

  // ----------------------------------------------------------------------
  // auto-convert rate timer
  // ----------------------------------------------------------------------
  logic [CNT_WIDTH-1:0] auto_cnt;

  // the period runs only in auto mode outside standby
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      auto_cnt     <= '0;
      auto_pending <= 1'b1;
    end else if (CLK_EN_I) begin
      if (!auto_mode || standby) begin
        auto_cnt     <= '0;
        auto_pending <= auto_mode;
      end else if (start_conv && state == DTC_IDLE) begin
        auto_cnt     <= '0;
        auto_pending <= 1'b0;
      end else if (auto_cnt == CNT_WIDTH'(AUTO_COUNT - 1)) begin
        auto_cnt     <= '0;
        auto_pending <= 1'b1;
      end else begin
        auto_cnt <= auto_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // results: remote held aside until both channels are done
  // ----------------------------------------------------------------------
  logic [7:0] remote_temp;
  logic [7:0] local_temp;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      remote_shadow <= TEMP_RST;
    end else if (CLK_EN_I && state == DTC_REMOTE && chan_done) begin
      remote_shadow <= REMOTE_SAMPLE_I;
    end
  end

  // published together, so readers never see a half-updated pair
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      remote_temp <= TEMP_RST;
      local_temp  <= TEMP_RST;
    end else if (CLK_EN_I && finish) begin
      remote_temp <= remote_shadow;
      local_temp  <= LOCAL_SAMPLE_I;
    end
  end

  // ----------------------------------------------------------------------
  // threshold comparison and sticky status
  // ----------------------------------------------------------------------
  logic [EVT_WIDTH-1:0] events;
  logic [EVT_WIDTH-1:0] flags;
  logic [EVT_WIDTH-1:0] clear_bits;
  logic [7:0]           status_byte;

  // signed compare on fresh values, same cycle as publication
  assign events[4] = finish && ($signed(LOCAL_SAMPLE_I) > $signed(local_high));
  assign events[3] = finish && ($signed(LOCAL_SAMPLE_I) < $signed(local_low));
  assign events[2] = finish && ($signed(remote_shadow) > $signed(remote_high));
  assign events[1] = finish && ($signed(remote_shadow) < $signed(remote_low));
  assign events[0] = finish;

  assign clear_bits = {REG_WDATA_I[ST_LHIGH_BIT], REG_WDATA_I[ST_LLOW_BIT],
                       REG_WDATA_I[ST_RHIGH_BIT], REG_WDATA_I[ST_RLOW_BIT],
                       REG_WDATA_I[ST_DONE_BIT]};

  // set wins over a write-one clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < EVT_WIDTH; g++) begin : g_flag
      always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          flags[g] <= 1'b0;
        end else if (CLK_EN_I) begin
          if (events[g]) begin
            flags[g] <= 1'b1;
          end else if (REG_WR_I && REG_ADDR_I == REG_STATUS && clear_bits[g]) begin
            flags[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    status_byte                = 8'h00;
    status_byte[ST_BUSY_BIT]   = (state != DTC_IDLE);
    status_byte[ST_LHIGH_BIT]  = flags[4];
    status_byte[ST_LLOW_BIT]   = flags[3];
    status_byte[ST_RHIGH_BIT]  = flags[2];
    status_byte[ST_RLOW_BIT]   = flags[1];
    status_byte[ST_DONE_BIT]   = flags[0];
  end

  // ----------------------------------------------------------------------
  // interrupt and open-drain alert
  // ----------------------------------------------------------------------
  logic irq_level;

  assign irq_level = |(status_byte & irq_mask & ~(8'h01 << ST_BUSY_BIT));

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else if (CLK_EN_I) begin
      IRQ_O <= irq_level;
    end
  end

  // pin only ever driven low; the pull-up makes it high
  assign ALERT_O    = 1'b0;
  assign ALERT_OE_O = IRQ_O;

  assign ADC_ACTIVE_O = (state != DTC_IDLE);

  // ----------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (CLK_EN_I) begin
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          REG_REMOTE_TEMP: REG_RDATA_O <= remote_temp;
          REG_LOCAL_TEMP:  REG_RDATA_O <= local_temp;
          REG_STATUS:      REG_RDATA_O <= status_byte;
          REG_CONFIG:      REG_RDATA_O <= config_reg;
          REG_LOCAL_HIGH:  REG_RDATA_O <= local_high;
          REG_LOCAL_LOW:   REG_RDATA_O <= local_low;
          REG_REMOTE_HIGH: REG_RDATA_O <= remote_high;
          REG_REMOTE_LOW:  REG_RDATA_O <= remote_low;
          REG_IRQ_MASK:    REG_RDATA_O <= irq_mask;
          REG_ADDR:        REG_RDATA_O <= {6'h00, BUS_ADDRESS_O};
          default:         REG_RDATA_O <= 8'h00;
        endcase
      end else begin
        REG_RDATA_O <= 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

//--- dtc_top_sva.sv
// checker for the temperature conversion controller ports
`timescale 1ns/10ps
`default_nettype none
module dtc_top_chk
  import dtc_pkg::*;
#(
  parameter int unsigned CHAN_COUNT = 8
) (
  input wire logic       CLK_SYS_I,
  input wire logic       RST_N_I,
  input wire logic       HW_STANDBY_IN_N_I,
  input wire logic       ALERT_OE_O,
  input wire logic       ALERT_O,
  input wire logic       ADC_ACTIVE_O,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic [1:0] BUS_ADDRESS_O,
  input wire logic       IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // ----------------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------------
  int unsigned act_cnt;
  logic [2:0]  since_rst;
  // active run length, and edges since reset saturating at seven
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      act_cnt   <= 0;
      since_rst <= 3'h0;
    end else begin
      act_cnt   <= ADC_ACTIVE_O ? act_cnt + 1 : 0;
      since_rst <= (since_rst == 3'h7) ? since_rst : since_rst + 3'h1;
    end
  end
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_alert_low_only: assert property (ALERT_O == 1'b0)
    else $error("alert drive value not low");
  a_irq_to_alert: assert property ($rose(IRQ_O) |-> ##[0:1] ALERT_OE_O)
    else $error("alert not pulled after interrupt");
  a_alert_released: assert property (!IRQ_O [*2] |-> !ALERT_OE_O)
    else $error("alert pulled without interrupt");
  a_rdata_idle: assert property (!REG_RD_I |=> REG_RDATA_O == 8'h00)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (REG_RD_I && REG_ADDR_I > 4'hA |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_standby_idle: assert property (!HW_STANDBY_IN_N_I [*4] |-> !ADC_ACTIVE_O)
    else $error("conversion active in standby");
  a_addr_frozen: assert property (since_rst == 3'h7 |-> $stable(BUS_ADDRESS_O))
    else $error("bus address changed after capture");
  a_run_length: assert property (ADC_ACTIVE_O |-> act_cnt < 2 * CHAN_COUNT)
    else $error("conversion longer than two intervals");
  a_busy_bit: assert property (REG_RD_I && REG_ADDR_I == REG_STATUS
                               |=> REG_RDATA_O[ST_BUSY_BIT] == $past(ADC_ACTIVE_O))
    else $error("busy bit disagrees with conversion");
endmodule
bind dtc_top dtc_top_chk #(.CHAN_COUNT(CHAN_COUNT)) chk_u (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .HW_STANDBY_IN_N_I(HW_STANDBY_IN_N_I),
  .ALERT_OE_O(ALERT_OE_O), .ALERT_O(ALERT_O), .ADC_ACTIVE_O(ADC_ACTIVE_O),
  .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .BUS_ADDRESS_O(BUS_ADDRESS_O), .IRQ_O(IRQ_O));
`default_nettype wire

//--- dtc_far_model.sv
// far-side model: front-end samples and pulled-up alert line
`timescale 1ns/10ps
`default_nettype none
module dtc_far_model (
  input  wire logic       alert_oe_i,
  input  wire logic       alert_i,
  output logic            alert_line_o,
  output logic [7:0]      remote_o,
  output logic [7:0]      local_o
);
  // ----------------------------------------------------------------------
  // line and samples
  // ----------------------------------------------------------------------
  // pull-up gives the idle level, the device may only sink it
  assign alert_line_o = alert_oe_i ? alert_i : 1'b1;
  initial begin
    remote_o = 8'h00;
    local_o  = 8'h00;
  end
  // samples change between conversions only
  task automatic set_samples(input logic [7:0] r, input logic [7:0] l);
    remote_o = r;
    local_o  = l;
  endtask
endmodule
`default_nettype wire

//--- dtc_top_bench.sv
// self-checking bench for the temperature conversion controller
`timescale 1ns/10ps
`default_nettype none
module dtc_top_bench;
  import dtc_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       hw_standby_in_n = 1'b0;
  logic [1:0] sel = 2'h2;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  wire logic       alert_oe, alert_drv, adc_active, irq, alert_line;
  wire logic [7:0] rdata, remote_s, local_s;
  wire logic [1:0] bus_addr;
  int errors = 0;
  int n_compared = 0;
  int act_cycles = 0;
  // ----------------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------------
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (adc_active === 1'b1) act_cycles++;
  // short intervals keep the run brief
  dtc_top #(.CHAN_COUNT(8), .AUTO_COUNT(40)) dut_u (
    .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .CLK_EN_I(1'b1),
    .HW_STANDBY_IN_N_I(hw_standby_in_n), .ADDR_SELECT_0_I(sel[0]), .ADDR_SELECT_1_I(sel[1]),
    .ALERT_OE_O(alert_oe), .ALERT_O(alert_drv), .REMOTE_SAMPLE_I(remote_s),
    .LOCAL_SAMPLE_I(local_s), .ADC_ACTIVE_O(adc_active), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(rdata),
    .BUS_ADDRESS_O(bus_addr), .IRQ_O(irq));
  dtc_far_model far_u (.alert_oe_i(alert_oe), .alert_i(alert_drv),
    .alert_line_o(alert_line), .remote_o(remote_s), .local_o(local_s));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  // bounded wait for a conversion to end
  task automatic wait_idle();
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_sys);
      #1;
      if (adc_active === 1'b0 && act_cycles > 0) break;
    end
    check({6'h00, adc_active, act_cycles == 0}, 8'h00);
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    chk_rd(REG_CONFIG, CONFIG_RST);
    chk_rd(REG_LOCAL_HIGH, HIGH_RST);
    chk_rd(REG_LOCAL_LOW, LOW_RST);
    chk_rd(REG_REMOTE_HIGH, HIGH_RST);
    chk_rd(REG_REMOTE_LOW, LOW_RST);
    chk_rd(REG_IRQ_MASK, MASK_RST);
    chk_rd(REG_REMOTE_TEMP, TEMP_RST);
    chk_rd(REG_ADDR, 8'h02);
    chk_rd(4'hF, 8'h00);
    sel <= 2'h1;
    repeat (5) @(posedge clk_sys);
    check({6'h00, bus_addr}, 8'h02);
    wr(REG_CONFIG, 8'h40);
    $display("test reset done");
  endtask
  task automatic t_pin_standby();
    act_cycles = 0;
    wr(REG_ONE_SHOT, 8'h01);
    repeat (30) @(posedge clk_sys);
    check(act_cycles[7:0], 8'h00);
    $display("test pin standby done");
  endtask
  task automatic t_convert();
    far_u.set_samples(8'h50, 8'hC0);
    hw_standby_in_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    act_cycles = 0;
    wr(REG_ONE_SHOT, 8'h01);
    chk_rd(REG_STATUS, 8'h80);
    chk_rd(REG_REMOTE_TEMP, TEMP_RST);
    wait_idle();
    check(act_cycles[7:0], 8'h10);
    chk_rd(REG_REMOTE_TEMP, 8'h50);
    chk_rd(REG_LOCAL_TEMP, 8'hC0);
    chk_rd(REG_STATUS, 8'h31);
    check({7'h00, alert_line}, 8'h01);
    wr(REG_IRQ_MASK, 8'h39);
    repeat (2) @(posedge clk_sys);
    #1;
    check({6'h00, irq, alert_line}, 8'h02);
    wr(REG_STATUS, 8'h39);
    repeat (3) @(posedge clk_sys);
    #1;
    check({6'h00, irq, alert_line}, 8'h01);
    $display("test convert done");
  endtask
  task automatic t_abort();
    far_u.set_samples(8'h11, 8'h22);
    act_cycles = 0;
    wr(REG_ONE_SHOT, 8'h01);
    repeat (5) @(posedge clk_sys);
    hw_standby_in_n <= 1'b0;
    wait_idle();
    wr(REG_REMOTE_HIGH, 8'h7F);
    chk_rd(REG_REMOTE_HIGH, 8'h7F);
    chk_rd(REG_REMOTE_TEMP, 8'h50);
    chk_rd(REG_LOCAL_TEMP, 8'hC0);
    chk_rd(REG_STATUS, 8'h00);
    $display("test abort done");
  endtask
  task automatic t_halt_auto();
    wr(REG_CONFIG, 8'h41);
    hw_standby_in_n <= 1'b1;
    act_cycles = 0;
    repeat (100) @(posedge clk_sys);
    check(act_cycles[7:0], 8'h00);
    wr(REG_CONFIG, 8'h01);
    wait_idle();
    chk_rd(REG_REMOTE_TEMP, 8'h11);
    chk_rd(REG_LOCAL_TEMP, 8'h22);
    far_u.set_samples(8'h33, 8'h44);
    wr(REG_ONE_SHOT, 8'h01);
    wr(REG_CONFIG, 8'h41);
    wait_idle();
    chk_rd(REG_REMOTE_TEMP, 8'h11);
    chk_rd(REG_LOCAL_TEMP, 8'h22);
    $display("test halt and auto done");
  endtask
  // ----------------------------------------------------------------------
  // sequence, verdict and watchdog
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_pin_standby();
    t_convert();
    t_abort();
    t_halt_auto();
    close_out();
  end
  // whole run needs about three hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
